// *** verification/dcsm_core_props.sv ***
// checker for the drive control state machine ports
`timescale 1ns/100ps
`default_nettype none
module dcsm_core_props (
  input wire clk_i,
  input wire rst_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire [15:0] cmd_word_o,
  input wire [15:0] stat_word_o,
  input wire power_on_o,
  input wire loops_on_o,
  input wire targets_on_o,
  input wire inhibit_neg_o,
  input wire inhibit_pos_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_CMD_TAKEN: assert property (wr_i && addr_i == 16'h6040 |=> cmd_word_o == $past(wdata_i))
    else $error("command word not taken");
  AST_FAULT_UNPOWERED: assert property (stat_word_o[3:0] == 4'h8 |-> !power_on_o)
    else $error("power on in fault");
  AST_FRA_POWERED: assert property (stat_word_o[3:0] == 4'hF |-> power_on_o && loops_on_o && targets_on_o)
    else $error("fault reaction without power");
  AST_FRA_LEAVES: assert property ($rose(stat_word_o[3:0] == 4'hF) |-> ##[1:1000] stat_word_o[3:0] == 4'h8)
    else $error("fault reaction never ends");
  AST_VOLT_BIT: assert property (stat_word_o[4] == power_on_o)
    else $error("voltage bit wrong");
  AST_TOP_ZERO: assert property (stat_word_o[15:13] == 3'h0)
    else $error("top status bits set");
  AST_INH_NEG: assert property (cmd_word_o[12] && $past(cmd_word_o[12]) |-> inhibit_neg_o)
    else $error("negative inhibit missing");
  AST_INH_POS: assert property (cmd_word_o[13] && $past(cmd_word_o[13]) |-> inhibit_pos_o)
    else $error("positive inhibit missing");
  AST_FAULT_RESET: assert property (stat_word_o[3:0] == 4'h8 && $rose(cmd_word_o[7]) |-> ##[1:3] stat_word_o[6])
    else $error("fault reset ignored");
  cover property (stat_word_o[3:0] == 4'h8);
  cover property (stat_word_o[6:0] == 7'h07);
  cover property (inhibit_pos_o);
endmodule // dcsm_core_props
bind dcsm_core dcsm_core_props u_props (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .cmd_word_o(cmd_word_o), .stat_word_o(stat_word_o), .power_on_o(power_on_o),
  .loops_on_o(loops_on_o), .targets_on_o(targets_on_o), .inhibit_neg_o(inhibit_neg_o), .inhibit_pos_o(inhibit_pos_o));
`default_nettype wire

// *** verification/dcsm_host_model.sv ***
// host model issuing command and status word accesses
`timescale 1ns/100ps
`default_nettype none
module dcsm_host_model (
  input wire logic clk_i,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [15:0] rdata_i
);
  initial begin
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // a whole command pattern goes out in one write
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    // released lines must not keep the last value
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule // dcsm_host_model
`default_nettype wire

// *** verification/drive_control_state_machine_tb_top.sv ***
// self-checking bench of the drive control state machine
`timescale 1ns/100ps
`default_nettype none
module drive_control_state_machine_tb_top;
  logic clk_i = 0, rst_i = 1, init_done_i = 0, drive_enable_i = 1, fault_i = 0;
  logic homing_mode_i = 0, at_command_i = 0, standstill_i = 0, service_owns_i = 0;
  logic fatal_i = 0, custom_mode_i = 0, home_reached_i = 0;
  logic [7:0] events_i = 8'h01, warn_mask_i = 8'h01, mfr_mask_i = 8'h02, limit_mask_i = 8'h04;
  wire [15:0] addr_i, wdata_i, rdata_o, cmd_word_o, stat_word_o;
  wire wr_i, rd_i, power_on_o, loops_on_o, targets_on_o, stop_decel_o, hold_o;
  wire fault_react_o, homing_o, inhibit_neg_o, inhibit_pos_o, fault_clear_o;
  int mismatches = 0, samples_checked = 0;
  logic [15:0] rv;
  dcsm_core #(.FRA_CYCLES(20), .PDD_CYCLES(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmd_word_o(cmd_word_o),
    .stat_word_o(stat_word_o), .init_done_i(init_done_i), .drive_enable_i(drive_enable_i), .fault_i(fault_i),
    .fatal_i(fatal_i), .homing_mode_i(homing_mode_i), .custom_mode_i(custom_mode_i),
    .home_reached_i(home_reached_i),
    .at_command_i(at_command_i), .standstill_i(standstill_i), .service_owns_i(service_owns_i),
    .events_i(events_i), .warn_mask_i(warn_mask_i), .mfr_mask_i(mfr_mask_i), .limit_mask_i(limit_mask_i),
    .power_on_o(power_on_o), .loops_on_o(loops_on_o), .targets_on_o(targets_on_o), .stop_decel_o(stop_decel_o),
    .hold_o(hold_o), .fault_react_o(fault_react_o), .homing_o(homing_o), .inhibit_neg_o(inhibit_neg_o),
    .inhibit_pos_o(inhibit_pos_o), .fault_clear_o(fault_clear_o));
  dcsm_host_model u_host (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i),
    .rdata_i(rdata_o));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ck1(input string n, input logic e, input logic g);
    chk(n, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic st(input logic [15:0] m, input logic [15:0] e);
    chk("stat_word_o", e, stat_word_o & m);
  endtask
  task automatic cmd(input logic [15:0] d);
    u_host.wr(16'h6040, d);
    repeat (3) @(negedge clk_i);
  endtask
  task automatic up();
    cmd(16'h0006);
    st(16'h006F, 16'h0021);
    cmd(16'h0007);
    st(16'h006F, 16'h0023);
    cmd(16'h000F);
    st(16'h007F, 16'h0037);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // the scenarios need about 250 cycles
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (10) @(negedge clk_i);
    chk("reset", 16'h0000, stat_word_o);
    rst_i = 0;
    init_done_i = 1;
    repeat (3) @(negedge clk_i);
    st(16'h004F, 16'h0040);
    st(16'hE280, 16'h0280);
    events_i = 8'h06;
    repeat (3) @(negedge clk_i);
    st(16'h0980, 16'h0900);
    events_i = 8'h01;
    cmd(16'h000F);
    st(16'h004F, 16'h0040);
    up();
    cmd(16'h100F);
    ck1("inhibit_neg_o", 1'b1, inhibit_neg_o);
    cmd(16'h200F);
    ck1("inhibit_pos_o", 1'b1, inhibit_pos_o);
    u_host.rd(16'h6040, rv);
    chk("rd_cmd", 16'h200F, rv);
    u_host.wr(16'h6041, 16'hFFFF);
    u_host.rd(16'h6041, rv);
    chk("rd_stat", 16'h02B7, rv);
    u_host.rd(16'h1234, rv);
    chk("rd_unmapped", 16'h0000, rv);
    service_owns_i = 1;
    at_command_i = 1;
    repeat (3) @(negedge clk_i);
    st(16'h067F, 16'h0437);
    service_owns_i = 0;
    homing_mode_i = 1;
    cmd(16'h001F);
    ck1("homing_o", 1'b1, homing_o);
    home_reached_i = 1;
    repeat (3) @(negedge clk_i);
    st(16'h1400, 16'h1400);
    cmd(16'h000F);
    ck1("homing_o", 1'b0, homing_o);
    st(16'h1000, 16'h1000);
    homing_mode_i = 0;
    custom_mode_i = 1;
    at_command_i = 0;
    repeat (3) @(negedge clk_i);
    st(16'h0400, 16'h0000);
    custom_mode_i = 0;
    home_reached_i = 0;
    cmd(16'h0002);
    st(16'h006F, 16'h0007);
    ck1("stop_decel_o", 1'b1, stop_decel_o);
    standstill_i = 1;
    repeat (3) @(negedge clk_i);
    ck1("hold_o", 1'b1, hold_o);
    cmd(16'h000F);
    st(16'h006F, 16'h0027);
    cmd(16'h0002);
    cmd(16'h0000);
    repeat (30) @(negedge clk_i);
    st(16'h004F, 16'h0040);
    standstill_i = 0;
    up();
    fault_i = 1;
    repeat (4) @(negedge clk_i);
    st(16'h004F, 16'h000F);
    ck1("fault_react_o", 1'b1, fault_react_o);
    repeat (40) @(negedge clk_i);
    st(16'h005F, 16'h0008);
    fault_i = 0;
    u_host.wr(16'h6040, 16'h0080);
    @(negedge clk_i);
    ck1("fault_clear_o", 1'b1, fault_clear_o);
    st(16'h004F, 16'h0040);
    fatal_i = 1;
    cmd(16'h0006);
    u_host.wr(16'h6040, 16'h0000);
    @(negedge clk_i);
    ck1("fault_clear_o", 1'b1, fault_clear_o);
    @(negedge clk_i);
    ck1("fault_clear_o", 1'b0, fault_clear_o);
    fatal_i = 0;
    up();
    cmd(16'h0002);
    drive_enable_i = 0;
    repeat (3) @(negedge clk_i);
    st(16'h007F, 16'h0017);
    repeat (15) @(negedge clk_i);
    st(16'h007F, 16'h0040);
    cmd(16'h0006);
    cmd(16'h0007);
    st(16'h006F, 16'h0021);
    drive_enable_i = 1;
    rst_i = 1;
    init_done_i = 0;
    @(negedge clk_i);
    chk("reset", 16'h0000, stat_word_o);
    rst_i = 0;
    repeat (3) @(negedge clk_i);
    st(16'h004F, 16'h0000);
    init_done_i = 1;
    repeat (2) @(negedge clk_i);
    st(16'h004F, 16'h0040);
    print_verdict();
  end
endmodule // drive_control_state_machine_tb_top
`default_nettype wire

// *** verilog/dcsm_core.v ***
// drive control state machine with command and status words
`timescale 1ns/100ps
`default_nettype none
`include "dcsm_regs.vh"
// Behaviour
// - quick stop active decelerates motor under the stop deceleration limit, power on
// - once stopped in quick stop, hold position or zero velocity
// - enable operation in quick stop returns to operation enabled
// - disable voltage or drive enable loss in quick stop: delay then switch-on-disabled
// - fault reaction active runs configured reaction with power and loops on
// - fault reaction leaves to fault by itself after 100us to 2ms
// - fault state keeps power stage off until reset
// - rising edge of command bit 7 moves fault to switch-on-disabled
// - with bit 7 low decode shutdown, switch on, enable, quick stop, disable voltage
// - homing mode: bit 4 high begins homing, low ends it, with enable pattern
// - command bit 12 inhibits negative motion by configured action
// - command bit 13 inhibits positive motion by configured action
// - status bits encode not-ready, disabled, ready, switched on, enabled
// - status bits encode fault reaction, fault and quick stop active
// - status bit 4 set whenever power is applied to the motor
// - status bits 7, 8, 11 set by masked internal events
// - status bit 9 low while service channel owns access, else high
// - status bit 10 shows home reached in homing, else at command
// - status bit 12 high once homing completed
// - not ready moves to switch-on-disabled after initialization completes
// - entering switch-on-disabled with fatal error performs automatic fault reset
// - shutdown in switch-on-disabled moves to ready to switch on
// - quick stop in operation enabled moves to quick stop active
module dcsm_core #(
  parameter FRA_CYCLES = `DCSM_FRA_CYCLES,
  parameter PDD_CYCLES = `DCSM_PDD_CYCLES,
  parameter EVW = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire [15:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  output reg [15:0] cmd_word_o,
  output reg [15:0] stat_word_o,
  input wire init_done_i,
  input wire drive_enable_i,
  input wire fault_i,
  input wire fatal_i,
  input wire homing_mode_i,
  input wire custom_mode_i,
  input wire home_reached_i,
  input wire at_command_i,
  input wire standstill_i,
  input wire service_owns_i,
  input wire [EVW-1:0] events_i,
  input wire [EVW-1:0] warn_mask_i,
  input wire [EVW-1:0] mfr_mask_i,
  input wire [EVW-1:0] limit_mask_i,
  output reg power_on_o,
  output reg loops_on_o,
  output reg targets_on_o,
  output reg stop_decel_o,
  output reg hold_o,
  output reg fault_react_o,
  output reg homing_o,
  output reg inhibit_neg_o,
  output reg inhibit_pos_o,
  output reg fault_clear_o
);
  localparam [3:0] ST_NRDY = 4'h0;
  localparam [3:0] ST_SOD = 4'h1;
  localparam [3:0] ST_RDY = 4'h2;
  localparam [3:0] ST_SWON = 4'h3;
  localparam [3:0] ST_OPEN = 4'h4;
  localparam [3:0] ST_QSA = 4'h5;
  localparam [3:0] ST_FRA = 4'h6;
  localparam [3:0] ST_FLT = 4'h7;
  localparam [3:0] ST_PDD = 4'h8;

  localparam [2:0] C_NONE = 3'h0;
  localparam [2:0] C_DISV = 3'h1;
  localparam [2:0] C_SHUT = 3'h2;
  localparam [2:0] C_SWON = 3'h3;
  localparam [2:0] C_ENOP = 3'h4;
  localparam [2:0] C_QSTP = 3'h5;

  // decode order matters: disable voltage and quick stop overlap other masks
  function [2:0] decode_cmd;
    input [15:0] cw;
    begin
      if (cw[`DCSM_CW_RESET_BIT])
        decode_cmd = C_NONE;
      else if (!cw[1])
        decode_cmd = C_DISV;
      else if (!cw[2])
        decode_cmd = C_QSTP;
      else if (!cw[0])
        decode_cmd = C_SHUT;
      else if (!cw[3])
        decode_cmd = C_SWON;
      else
        decode_cmd = C_ENOP;
    end
  endfunction

  function [6:0] state_bits;
    input [3:0] st;
    begin
      case (st)
        ST_NRDY: state_bits = 7'b0000000;
        ST_SOD: state_bits = 7'b1000000;
        ST_PDD: state_bits = 7'b0000111;
        ST_RDY: state_bits = 7'b0100001;
        ST_SWON: state_bits = 7'b0100011;
        ST_OPEN: state_bits = 7'b0100111;
        ST_FRA: state_bits = 7'b0001111;
        ST_FLT: state_bits = 7'b0001000;
        ST_QSA: state_bits = 7'b0000111;
        default: state_bits = 7'b0000000;
      endcase
    end
  endfunction

  // the delay state still drives the motor, so it counts as powered
  function is_powered;
    input [3:0] st;
    begin
      case (st)
        ST_SWON, ST_OPEN, ST_QSA, ST_FRA, ST_PDD: is_powered = 1'b1;
        default: is_powered = 1'b0;
      endcase
    end
  endfunction

  reg [3:0] state;
  reg [3:0] next_state;
  reg reset_bit_d;
  reg fault_d;
  reg homed;
  wire [2:0] cmd;
  wire reset_edge;
  wire fault_edge;
  wire fra_done;
  wire pdd_done;
  reg start_fra;
  reg start_pdd;
  wire [6:0] sb;
  wire homing_req;
  wire next_powered;
  wire next_targets;
  wire next_qs_area;
  wire enter_sod;
  wire [2:0] ev_flag;
  wire [3*EVW-1:0] ev_masks;
  wire [19:0] timer_load;
  reg [15:0] next_stat;
  localparam [19:0] FRA_LOAD = FRA_CYCLES[19:0];
  localparam [19:0] PDD_LOAD = PDD_CYCLES[19:0];
  genvar gi;

  assign cmd = decode_cmd(cmd_word_o);
  // edge, not level: a bit 7 left high must not clear a later fault
  assign reset_edge = cmd_word_o[`DCSM_CW_RESET_BIT] & ~reset_bit_d;
  // a standing fault input enters the reaction once only
  assign fault_edge = fault_i & ~fault_d;
  assign sb = state_bits(next_state);
  assign homing_req = homing_mode_i & (cmd_word_o[3:0] == 4'hF) &
    cmd_word_o[`DCSM_CW_HOME_BIT] & ~cmd_word_o[`DCSM_CW_RESET_BIT];
  assign next_powered = is_powered(next_state);
  assign next_targets = (next_state == ST_OPEN) | (next_state == ST_FRA);
  assign next_qs_area = (next_state == ST_QSA) | (next_state == ST_PDD);
  assign enter_sod = (next_state == ST_SOD) & (state != ST_SOD);
  assign timer_load = start_fra ? FRA_LOAD : PDD_LOAD;
  assign ev_masks = {limit_mask_i, mfr_mask_i, warn_mask_i};

  // warning, maker and limit flags share one masking scheme
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_evt
      assign ev_flag[gi] = |(events_i & ev_masks[gi*EVW +: EVW]);
    end
  endgenerate

  // two timers would share nothing, one instance serves both since the states exclude each other
  dcsm_timer #(.W(20)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_fra | start_pdd),
    .load_i(timer_load),
    .done_o(fra_done),
    .busy_o()
  );
  assign pdd_done = fra_done;

  always @* begin
    next_state = state;
    start_fra = 1'b0;
    start_pdd = 1'b0;
    // a fault outranks any command pattern in the same cycle
    if (fault_edge && state != ST_FRA && state != ST_FLT && state != ST_NRDY) begin
      next_state = ST_FRA;
      start_fra = 1'b1;
    end else begin
      case (state)
        ST_NRDY: if (init_done_i) next_state = ST_SOD;
        ST_SOD: if (cmd == C_SHUT) next_state = ST_RDY;
        ST_RDY: begin
          // no switch on against an open hardware enable
          if (cmd == C_SWON && drive_enable_i) next_state = ST_SWON;
          else if (cmd == C_DISV || cmd == C_QSTP) next_state = ST_SOD;
        end
        ST_SWON: begin
          if (!drive_enable_i || cmd == C_DISV || cmd == C_QSTP) next_state = ST_SOD;
          else if (cmd == C_ENOP) next_state = ST_OPEN;
          else if (cmd == C_SHUT) next_state = ST_RDY;
        end
        ST_OPEN: begin
          if (!drive_enable_i || cmd == C_DISV) next_state = ST_SOD;
          else if (cmd == C_QSTP) next_state = ST_QSA;
          else if (cmd == C_SHUT) next_state = ST_RDY;
          else if (cmd == C_SWON) next_state = ST_SWON;
        end
        ST_QSA: begin
          // bridge stays on through the delay before it is released
          if (!drive_enable_i || cmd == C_DISV) begin
            next_state = ST_PDD;
            start_pdd = 1'b1;
          end else if (cmd == C_ENOP) next_state = ST_OPEN;
        end
        ST_PDD: if (pdd_done) next_state = ST_SOD;
        ST_FRA: if (fra_done) next_state = ST_FLT;
        ST_FLT: if (reset_edge) next_state = ST_SOD;
        default: next_state = ST_NRDY;
      endcase
    end
  end

  // built from the state being entered so the word changes on the state's own edge
  always @* begin
    next_stat = 16'h0000;
    next_stat[3:0] = sb[3:0];
    next_stat[5] = sb[5];
    next_stat[6] = sb[6];
    next_stat[`DCSM_SW_VOLT_BIT] = next_powered;
    next_stat[`DCSM_SW_WARN_BIT] = ev_flag[0];
    next_stat[`DCSM_SW_MFR_BIT] = ev_flag[1];
    next_stat[`DCSM_SW_LIMIT_BIT] = ev_flag[2];
    next_stat[`DCSM_SW_REMOTE_BIT] = ~service_owns_i;
    next_stat[`DCSM_SW_TARGET_BIT] = (homing_mode_i | (custom_mode_i & homing_o)) ?
      home_reached_i : at_command_i;
    next_stat[`DCSM_SW_HOMED_BIT] = homed;
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_NRDY;
      cmd_word_o <= `DCSM_CMD_RESET_VAL;
      stat_word_o <= 16'h0000;
      rdata_o <= 16'h0000;
      reset_bit_d <= 1'b0;
      fault_d <= 1'b0;
      homed <= 1'b0;
      power_on_o <= 1'b0;
      loops_on_o <= 1'b0;
      targets_on_o <= 1'b0;
      stop_decel_o <= 1'b0;
      hold_o <= 1'b0;
      fault_react_o <= 1'b0;
      homing_o <= 1'b0;
      inhibit_neg_o <= 1'b0;
      inhibit_pos_o <= 1'b0;
      fault_clear_o <= 1'b0;
    end else begin
      state <= next_state;
      reset_bit_d <= cmd_word_o[`DCSM_CW_RESET_BIT];
      fault_d <= fault_i;
      if (wr_i && addr_i == `DCSM_OFS_CMD)
        cmd_word_o <= wdata_i;
      if (rd_i)
        rdata_o <= (addr_i == `DCSM_OFS_CMD) ? cmd_word_o :
                   (addr_i == `DCSM_OFS_STAT) ? stat_word_o : 16'h0000;
      // power stage on only where the drive must apply energy
      power_on_o <= next_powered;
      loops_on_o <= next_powered;
      targets_on_o <= next_targets;
      stop_decel_o <= (next_state == ST_QSA) & ~standstill_i;
      // held through the delay too, the shaft must not drift while the bridge winds down
      hold_o <= next_qs_area & standstill_i;
      fault_react_o <= (next_state == ST_FRA);
      // automatic fault clear when arriving in switch-on-disabled with a fatal error
      fault_clear_o <= (enter_sod & fatal_i) | ((state == ST_FLT) & reset_edge);
      homing_o <= homing_req & (next_state == ST_OPEN);
      if (homing_req && !homing_o)
        homed <= 1'b0;
      else if (homing_o && home_reached_i)
        homed <= 1'b1;
      inhibit_neg_o <= cmd_word_o[`DCSM_CW_INH_NEG_BIT];
      inhibit_pos_o <= cmd_word_o[`DCSM_CW_INH_POS_BIT];
      stat_word_o <= next_stat;
    end
  end
endmodule // dcsm_core
`default_nettype wire

// *** verilog/dcsm_regs.vh ***
// register offsets, field positions and timing constants of the drive control state machine
`ifndef DCSM_REGS_VH
`define DCSM_REGS_VH
`define DCSM_OFS_CMD 16'h6040
`define DCSM_OFS_STAT 16'h6041
`define DCSM_CW_RESET_BIT 7
`define DCSM_CW_HOME_BIT 4
`define DCSM_CW_INH_NEG_BIT 12
`define DCSM_CW_INH_POS_BIT 13
`define DCSM_SW_VOLT_BIT 4
`define DCSM_SW_WARN_BIT 7
`define DCSM_SW_MFR_BIT 8
`define DCSM_SW_REMOTE_BIT 9
`define DCSM_SW_TARGET_BIT 10
`define DCSM_SW_LIMIT_BIT 11
`define DCSM_SW_HOMED_BIT 12
`define DCSM_CMD_RESET_VAL 16'h0000
`define DCSM_CLK_MHZ 50
`define DCSM_FRA_MIN_US 100
`define DCSM_FRA_MAX_US 2000
`define DCSM_FRA_CYCLES (`DCSM_FRA_MIN_US * `DCSM_CLK_MHZ)
`define DCSM_PDD_US 10
`define DCSM_PDD_CYCLES (`DCSM_PDD_US * `DCSM_CLK_MHZ)
`endif

// *** verilog/dcsm_timer.v ***
// down counter used for the fault reaction and power disable delays
`timescale 1ns/100ps
`default_nettype none
module dcsm_timer #(
  parameter W = 20
) (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire [W-1:0] load_i,
  output reg done_o,
  output reg busy_o
);
  reg [W-1:0] cnt;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= {W{1'b0}};
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt <= load_i;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // dcsm_timer
`default_nettype wire
